// >>> bench/esp_link_master.sv
// Link master model: clock frames on the clock pin, service bytes both ways.
// Assumes data is the block's data pin and 400 ns link and service bit times.
`timescale 1ns/1ps
module esp_link_master
(
	output logic link_clk, // Clock pin, service rx
	input wire logic data, // Data pin from block
	input wire logic data_nb // Data pin of block without self-test
);
	logic [63:0] got_nb;
	initial link_clk = 1'b1;
	// Samples just before each rise, when the bit has settled
	task automatic frame(input int n, output logic [63:0] got);
		got = '0;
		got_nb = '0;
		#17;
		for (int i = 0; i < n; i++)
		begin
			link_clk = 1'b0;
			#200;
			got = {got[62:0], data};
			got_nb = {got_nb[62:0], data_nb};
			link_clk = 1'b1;
			#200;
		end
	endtask
	task automatic uart_send(input logic [7:0] b);
		// Keep pin edges off the system clock edge
		#17;
		link_clk = 1'b0;
		#400;
		for (int i = 0; i < 8; i++)
		begin
			link_clk = b[i];
			#400;
		end
		link_clk = 1'b1;
		#400;
	endtask
	// Mid-bit sampling tolerates a few cycles of transmit delay
	task automatic uart_recv(output logic [7:0] b);
		wait (data === 1'b0);
		#200;
		for (int i = 0; i < 8; i++)
		begin
			#400;
			b[i] = data;
		end
		#400;
	endtask
endmodule

// >>> bench/esp_serial_out_bench.sv
// Testbench for the serial position output: registers, frames, service link.
// Assumes the link master model drives the clock pin at 400 ns.
`timescale 1ns/1ps
module esp_serial_out_bench;
	import esp_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [POS_W-1:0] pos_i = 20'h0;
	logic bit_fault_i = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq_o, data_o, link_clk, err;
	logic data_nb;
	logic [63:0] got;
	logic [7:0] b;
	int error_cnt = 0;
	int checks_done = 0;
	always #25 clk = ~clk;
	esp_serial_out #(.BAUD_DIV(8)) uut (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o),
		.pos_i(pos_i), .bit_fault_i(bit_fault_i), .link_clk_i(link_clk), .data_o(data_o));
	// Second block without self-test, on the same bus and link clock
	esp_serial_out #(.BIT_OPTION(1'b0), .BAUD_DIV(8)) uut_nb (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .irq_o(), .pos_i(pos_i), .bit_fault_i(bit_fault_i),
		.link_clk_i(link_clk), .data_o(data_nb));
	esp_link_master lm (.link_clk(link_clk), .data(data_o), .data_nb(data_nb));
	task automatic close_out;
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [5:0] crc6(input logic [18:0] v);
		logic [5:0] c;
		logic fb;
		c = 6'h00;
		for (int i = 18; i >= 0; i--)
		begin
			fb = c[5] ^ v[i];
			c = {c[4:0], 1'b0};
			if (fb)
				c = c ^ 6'h03;
		end
		return c;
	endfunction
	task automatic t_reset;
		chk({irq_o, data_o}, 2'b01, "pins after reset");
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, CTRL_RST, "control reset value");
		apb(1'b0, ADDR_MASK, 32'h0);
		chk(rd, {28'h0, MASK_RST}, "mask reset value");
		apb(1'b0, 8'h20, 32'h0);
		chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
	endtask
	task automatic t_plain(input logic f);
		pos_i <= 20'h9a5c3;
		bit_fault_i <= f;
		apb(1'b1, ADDR_MASK, 32'h1);
		lm.frame(22, got);
		chk(got[20:0], {20'h9a5c3, f}, "plain word");
		chk(lm.got_nb[21:0], {1'b1, 20'h9a5c3, 1'b1}, "plain word no self-test");
		wt(300);
		chk({data_o, data_nb}, {f, 1'b1}, "data held during hold");
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[STS_FRAME], 1'b0, "done during hold");
		wt(420);
		chk({irq_o, data_o}, 2'b11, "idle after hold");
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[STS_FRAME], 1'b1, "frame done flag");
		wt(1);
		chk(irq_o, 1'b0, "irq after status read");
		apb(1'b0, ADDR_POS, 32'h0);
		chk(rd, {12'h0, 20'h9a5c3}, "latched angle, not busy");
	endtask
	task automatic t_biss(input logic f, input logic early);
		logic [18:0] v;
		logic [18:0] vn;
		v = {17'h1b2c5, ~f, 1'b1};
		vn = {17'h1b2c5, 2'b11};
		pos_i <= 20'h1b2c5;
		bit_fault_i <= f;
		apb(1'b1, ADDR_CTRL, 32'h0000_1101);
		lm.frame(29, got);
		chk(got[28:0], {4'b0010, v, ~crc6(v)}, "ack frame");
		chk(lm.got_nb[28:0], {4'b0010, vn, ~crc6(vn)}, "ack frame no self-test");
		if (early)
			lm.frame(2, got);
		wt(720);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[STS_EARLY], early, "request in quiet time");
	endtask
	task automatic t_service;
		apb(1'b1, ADDR_CTRL, 32'h0000_1402);
		apb(1'b1, ADDR_SVC, 32'ha5);
		lm.uart_recv(b);
		chk(b, 8'ha5, "service byte sent");
		lm.uart_send(8'h3c);
		wt(20);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[STS_RX], 1'b1, "service rx flag");
		chk(rd[STS_TXDONE], 1'b1, "service tx done flag");
		apb(1'b0, ADDR_SVC, 32'h0);
		chk(rd[7:0], 8'h3c, "service byte received");
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_plain(1'b0);
		t_plain(1'b1);
		t_biss(1'b0, 1'b0);
		t_biss(1'b1, 1'b1);
		t_service;
		close_out;
	end
	// Whole run is near 200 us; this cuts a hang
	initial
	begin
		#1000000;
		error_cnt++;
		close_out;
	end
endmodule

// >>> design/esp_pkg.sv
// Constants shared by the serial position output and its service link.
// Assumes a 20 MHz system clock and an APB master with 32-bit data.
package esp_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_POS = 8'h0c;
	localparam logic [7:0] ADDR_SVC = 8'h10;
	localparam int CTRL_BISS_BIT = 0;
	localparam int CTRL_SETUP_BIT = 1;
	localparam int CTRL_RES_LSB = 8;
	localparam int RES_W = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_1400;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_1f03;
	localparam int STS_W = 4;
	localparam int STS_FRAME = 0;
	localparam int STS_RX = 1;
	localparam int STS_TXDONE = 2;
	localparam int STS_EARLY = 3;
	localparam logic [STS_W-1:0] MASK_RST = 4'h0;
	localparam logic [RES_W-1:0] RES_MIN = 5'h0c;
	localparam logic [RES_W-1:0] RES_MAX = 5'h14;
	localparam int POS_W = 20;
	localparam int FRAME_W = 32;
	localparam int CNT_W = 6;
	localparam int CRC_W = 6;
	localparam logic [CRC_W-1:0] CRC_POLY = 6'h03;
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_HOLD_NS = 25000;
	localparam int HOLD_W = 10;
	localparam logic [HOLD_W-1:0] HOLD_CYC =
		HOLD_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int BAUD_W = 16;
	localparam int SVC_BITS = 10;
endpackage

// >>> design/esp_serial_out.sv
// Serial absolute position output: plain synchronous or acknowledged
// frame with CRC, plus a service byte link on the same pair of wires.
// Assumes pos_i and bit_fault_i come from logic on clk; link_clk_i is
// a pin driven by the external master and is sampled here.
// Summary of operation
// R1: After reset the block serves position frames, not the service link.
// R2: Plain mode: the master clocks, this block returns position on data.
// R3: Plain mode with self-test: error bit 0 when healthy, 1 on fault.
// R4: Plain mode without self-test: no error bit after the position.
// R5: Master spaces plain requests over bits times period plus 26 us.
// R6: Acknowledged mode: frame bits move only on master clock edges.
// R7: Acknowledged mode: first clock cycle of a frame drives acknowledge low.
// R8: Then a start bit of 1 and one bit of 0 follow.
// R9: Then the position, its length the configured resolution.
// R10: Then error bit, 1 healthy 0 fault, and warning bit held at 1.
// R11: Without self-test the acknowledged error bit is always 1.
// R12: Frame ends with 6-bit CRC, polynomial x^6+x+1, over position, error, warning.
// R13: CRC is sent most significant bit first, each bit inverted.
// R14: Start bit and its zero follower stay out of the CRC.
// R15: A 25 us quiet time must pass before a new request is taken.
// R16: Service mode: clock pair receives, data pair transmits service bytes.
// R17: Plain mode: position latched at first falling edge, sent MSB first.
// R18: Plain mode: data held for the hold-off interval, then back high.
// R19: Software enters service mode by setting a control bit.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module esp_serial_out
	import esp_pkg::*;
#(
	parameter bit BIT_OPTION = 1'b1,
	parameter int BAUD_DIV = 174
)
(
	input wire logic clk, // System clock, 20 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	output logic irq_o, // Interrupt, level
	input wire logic [esp_pkg::POS_W-1:0] pos_i, // Absolute angle field
	input wire logic bit_fault_i, // Self-test fault, high on fault
	input wire logic link_clk_i, // Master clock pin, service rx
	output logic data_o // Data pin, service tx
);
	import esp_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACK = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_HOLD = 4'b1000
	} esp_state_type;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	esp_svc_if svc();

	esp_svc_uart #(.BAUD_DIV(BAUD_DIV)) u_uart
	(
		.clk(clk),
		.resetn(resetn),
		.bus(svc.uart)
	);

	function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
		input logic b);
		logic fb;
		fb = c[CRC_W-1] ^ b;
		return {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
	endfunction

	logic [2:0] lclk_q;
	logic rise;
	logic fall;
	logic [31:0] ctrl_q;
	logic [STS_W-1:0] sts_q;
	logic [STS_W-1:0] mask_q;
	logic [31:0] prdata_q;
	logic [7:0] rx_q;
	esp_state_type st_q;
	logic data_q;
	logic [FRAME_W-1:0] frm_q;
	logic [FRAME_W-1:0] frm_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] nb_q;
	logic [CNT_W-1:0] nb_d;
	logic [HOLD_W-1:0] tmr_q;
	logic biss_q;
	logic [POS_W-1:0] pos_lat_q;
	logic [RES_W-1:0] res_q;
	logic [RES_W-1:0] res_raw;
	logic [RES_W-1:0] res;
	logic biss;
	logic setup;
	logic tmo;
	logic done_ev;
	logic early_ev;
	logic acc;
	logic mapped;
	logic sts_rd;
	logic [STS_W-1:0] ev;

	// Two flops before any use; lclk_q[2] only feeds edge detection
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			lclk_q <= 3'h7;
		else
			lclk_q <= {lclk_q[1:0], link_clk_i};
	end
	assign rise = lclk_q[1] & ~lclk_q[2];
	assign fall = ~lclk_q[1] & lclk_q[2];

	assign biss = ctrl_q[CTRL_BISS_BIT];
	assign setup = ctrl_q[CTRL_SETUP_BIT];
	assign res_raw = ctrl_q[CTRL_RES_LSB +: RES_W];
	assign res = (res_raw < RES_MIN) ? RES_MIN : (res_raw > RES_MAX) ? RES_MAX : res_raw;

	// Whole frame built in one cycle so the acknowledge cycle covers it
	always_comb
	begin
		int n;
		logic [CRC_W-1:0] crc;
		logic eb;
		frm_d = '0;
		n = 0;
		crc = '0;
		eb = 1'b0;
		if (biss)
		begin
			frm_d[FRAME_W-1] = 1'b1; // see R8
			frm_d[FRAME_W-2] = 1'b0; // see R14
			n = 2;
		end
		for (int i = POS_W - 1; i >= 0; i--)
		begin
			if (i < int'(res))
			begin
				frm_d[FRAME_W-1-n] = pos_i[i]; // see R9
				crc = crc_step(crc, pos_i[i]);
				n++;
			end
		end
		if (biss)
		begin
			eb = BIT_OPTION ? ~bit_fault_i : 1'b1; // see R10 // see R11
			frm_d[FRAME_W-1-n] = eb;
			crc = crc_step(crc, eb);
			frm_d[FRAME_W-2-n] = 1'b1; // see R10
			crc = crc_step(crc, 1'b1); // see R12
			n = n + 2;
			for (int k = CRC_W - 1; k >= 0; k--)
			begin
				frm_d[FRAME_W-1-n] = ~crc[k]; // see R13
				n++;
			end
		end
		else if (BIT_OPTION)
		begin
			frm_d[FRAME_W-1-n] = bit_fault_i; // see R3
			n++;
		end
		nb_d = CNT_W'(n); // see R4
	end

	// Quiet-time counter; any master edge restarts it
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tmr_q <= '0;
		else if (st_q == ST_IDLE || rise || fall)
			tmr_q <= '0;
		else if (tmr_q != HOLD_CYC)
			tmr_q <= tmr_q + 1'b1;
	end
	assign tmo = (tmr_q == HOLD_CYC) && lclk_q[1]; // see R15 // see R18
	assign done_ev = tmo && st_q != ST_IDLE && cnt_q == '0 && !setup;
	assign early_ev = (st_q == ST_HOLD) && fall && !setup;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= ST_IDLE;
			data_q <= 1'b1;
			frm_q <= '0;
			cnt_q <= '0;
			nb_q <= '0;
			biss_q <= 1'b0;
			pos_lat_q <= '0;
			res_q <= RES_MAX;
		end
		else if (setup)
		begin
			st_q <= ST_IDLE;
			data_q <= svc.tx_line; // see R16
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					data_q <= 1'b1;
					if (fall) // see R6 // see R17
					begin
						frm_q <= frm_d;
						nb_q <= nb_d;
						cnt_q <= nb_d;
						biss_q <= biss;
						pos_lat_q <= pos_i;
						res_q <= res;
						if (biss)
						begin
							data_q <= 1'b0; // see R7
							st_q <= ST_ACK;
						end
						else
							st_q <= ST_SHIFT; // see R2
					end
				end
				ST_ACK:
				begin
					if (rise)
						st_q <= ST_SHIFT;
					else if (tmo)
					begin
						data_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				ST_SHIFT:
				begin
					if (rise && cnt_q != '0)
					begin
						data_q <= frm_q[FRAME_W-1]; // see R17
						frm_q <= {frm_q[FRAME_W-2:0], 1'b0};
						cnt_q <= cnt_q - 1'b1;
					end
					else if (rise)
					begin
						if (biss_q)
							data_q <= 1'b0;
						st_q <= ST_HOLD;
					end
					else if (tmo)
					begin
						data_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				ST_HOLD:
				begin
					if (tmo) // see R15 // see R18
					begin
						data_q <= 1'b1;
						st_q <= ST_IDLE;
					end
				end
				default:
				begin
					data_q <= 1'b1;
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
	assign data_o = data_q;

	assign svc.en = setup;
	assign svc.rx_line = lclk_q[1]; // see R16
	assign svc.tx_data = pwdata[7:0];
	assign svc.tx_valid = acc && pwrite && paddr == ADDR_SVC && setup && svc.tx_ready;

	// APB slave: zero wait states, read data captured in the setup cycle
	assign acc = psel && penable;
	assign pready = 1'b1;
	assign mapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_MASK ||
		paddr == ADDR_POS || paddr == ADDR_SVC;
	assign pslverr = acc && !mapped;
	assign prdata = prdata_q;
	assign sts_rd = acc && !pwrite && paddr == ADDR_STATUS;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q <= CTRL_RST; // see R1
			mask_q <= MASK_RST;
		end
		else if (acc && pwrite)
		begin
			if (paddr == ADDR_CTRL)
				ctrl_q <= pwdata & CTRL_WMASK; // see R19
			if (paddr == ADDR_MASK)
				mask_q <= pwdata[STS_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			prdata_q <= '0;
		else if (psel && !penable)
		begin
			case (paddr)
				ADDR_CTRL: prdata_q <= ctrl_q;
				ADDR_STATUS: prdata_q <= {28'h0, sts_q};
				ADDR_MASK: prdata_q <= {28'h0, mask_q};
				ADDR_POS: prdata_q <= {st_q != ST_IDLE, 11'h0, pos_lat_q};
				ADDR_SVC: prdata_q <= {24'h0, rx_q};
				default: prdata_q <= '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rx_q <= '0;
		else if (svc.rx_valid)
			rx_q <= svc.rx_data;
	end

	// Only bits that were reported get cleared, and a new event wins
	always_comb
	begin
		ev = '0;
		ev[STS_FRAME] = done_ev;
		ev[STS_RX] = svc.rx_valid;
		ev[STS_TXDONE] = svc.tx_done;
		ev[STS_EARLY] = early_ev; // see R5
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sts_q <= '0;
		else
			sts_q <= (sts_q & ~(sts_rd ? prdata_q[STS_W-1:0] : '0)) | ev;
	end
	assign irq_o = |(sts_q & mask_q);

	property p_idle_high;
		(st_q == ST_IDLE && !setup && !$past(setup)) |-> data_q;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle data not high"); // see R18

	property p_ack_low;
		(st_q == ST_IDLE && fall && biss && !setup) |=> (st_q == ST_ACK && !data_q) ##1 !data_q;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("acknowledge not low"); // see R7

	property p_start_one;
		(st_q == ST_SHIFT && rise && biss_q && cnt_q == nb_q && !setup) |=> data_q;
	endproperty
	a_start_one: assert property (p_start_one) else $error("start bit not one"); // see R8

	property p_zero_follow;
		(st_q == ST_SHIFT && rise && biss_q && cnt_q == nb_q - 1'b1 && !setup) |=> !data_q;
	endproperty
	a_zero_follow: assert property (p_zero_follow) else $error("zero bit missing"); // see R8

	property p_ssi_msb;
		(st_q == ST_SHIFT && rise && !biss_q && cnt_q == nb_q && !setup)
			|=> data_q == pos_lat_q[res_q - 1'b1];
	endproperty
	a_ssi_msb: assert property (p_ssi_msb) else $error("plain frame not msb first"); // see R17

	property p_no_restart;
		(st_q == ST_HOLD && fall && !setup) |=> st_q == ST_HOLD;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("request taken in quiet time"); // see R15

	property p_frame_len;
		(st_q == ST_IDLE && fall && biss && !setup) |=> nb_q == CNT_W'(res_q) + 6'd10;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length wrong"); // see R9

	property p_setup_tx;
		(setup && $past(setup)) |=> data_q == $past(svc.tx_line);
	endproperty
	a_setup_tx: assert property (p_setup_tx) else $error("service tx not on data"); // see R16

	property p_done_flag;
		(st_q == ST_HOLD && tmo && !setup) |=> sts_q[STS_FRAME] && st_q == ST_IDLE;
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("frame end not flagged"); // see R18
endmodule

// >>> design/esp_svc_if.sv
// Signals between the frame logic and the service link serialiser.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface esp_svc_if;
	logic en;
	logic rx_line;
	logic tx_line;
	logic tx_valid;
	logic tx_ready;
	logic tx_done;
	logic [7:0] tx_data;
	logic rx_valid;
	logic [7:0] rx_data;
	modport uart(input en, rx_line, tx_valid, tx_data,
		output tx_line, tx_ready, tx_done, rx_valid, rx_data);
	modport core(output en, rx_line, tx_valid, tx_data,
		input tx_line, tx_ready, tx_done, rx_valid, rx_data);
endinterface

// >>> design/esp_svc_uart.sv
// Byte serialiser for the service setup protocol, 8N1 framing.
// Assumes rx_line is already synchronised to clk.
`timescale 1ns/1ps
module esp_svc_uart
	import esp_pkg::*;
#(
	parameter int BAUD_DIV = 174
)
(
	input wire logic clk, // System clock
	input wire logic resetn, // Async reset, active low
	esp_svc_if.uart bus // Link to frame logic
);
	logic [BAUD_W-1:0] tx_div_q;
	logic [3:0] tx_bits_q;
	logic [8:0] tx_sh_q;
	logic [BAUD_W-1:0] rx_div_q;
	logic [3:0] rx_bits_q;
	logic [7:0] rx_sh_q;

	assign bus.tx_ready = bus.en && (tx_bits_q == 4'h0);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bus.tx_line <= 1'b1;
			bus.tx_done <= 1'b0;
			tx_div_q <= '0;
			tx_bits_q <= 4'h0;
			tx_sh_q <= '0;
		end
		else
		begin
			bus.tx_done <= 1'b0;
			if (tx_bits_q == 4'h0)
			begin
				bus.tx_line <= 1'b1;
				if (bus.tx_valid && bus.en)
				begin
					bus.tx_line <= 1'b0;
					tx_sh_q <= {1'b1, bus.tx_data};
					tx_bits_q <= 4'(SVC_BITS);
					tx_div_q <= BAUD_W'(BAUD_DIV - 1);
				end
			end
			else if (tx_div_q != '0)
				tx_div_q <= tx_div_q - 1'b1;
			else
			begin
				tx_div_q <= BAUD_W'(BAUD_DIV - 1);
				tx_bits_q <= tx_bits_q - 1'b1;
				if (tx_bits_q > 4'h1)
				begin
					bus.tx_line <= tx_sh_q[0];
					tx_sh_q <= {1'b1, tx_sh_q[8:1]};
				end
				else
					bus.tx_done <= 1'b1;
			end
		end
	end

	// Sample mid-bit; a start bit that is gone at mid-bit is a glitch
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rx_div_q <= '0;
			rx_bits_q <= 4'h0;
			rx_sh_q <= '0;
			bus.rx_valid <= 1'b0;
			bus.rx_data <= '0;
		end
		else
		begin
			bus.rx_valid <= 1'b0;
			if (!bus.en)
				rx_bits_q <= 4'h0;
			else if (rx_bits_q == 4'h0)
			begin
				if (!bus.rx_line)
				begin
					rx_bits_q <= 4'(SVC_BITS);
					rx_div_q <= BAUD_W'(BAUD_DIV / 2);
				end
			end
			else if (rx_div_q != '0)
				rx_div_q <= rx_div_q - 1'b1;
			else
			begin
				rx_div_q <= BAUD_W'(BAUD_DIV - 1);
				rx_bits_q <= rx_bits_q - 1'b1;
				if (rx_bits_q == 4'(SVC_BITS) && bus.rx_line)
					rx_bits_q <= 4'h0;
				else if (rx_bits_q == 4'h1)
				begin
					bus.rx_valid <= bus.rx_line;
					bus.rx_data <= rx_sh_q;
				end
				else if (rx_bits_q != 4'(SVC_BITS))
					rx_sh_q <= {bus.rx_line, rx_sh_q[7:1]};
			end
		end
	end
endmodule
